// ==== verilog/qrs_xfer.sv ====
// Core-side data phase logic for the strobed graphics port
//
// Notes on behaviour
// - Ready may coincide with the first data
// - Capture anywhere within transmitter delay spread
// - Strobe edges may straddle one or two clocks
// - Quad rate moves four words per clock
// - Transmitter drives true and complement strobes
// - Falling-only capture alternates true and complement
// - Falling-only capture never uses complement rising edges
// - Differential pair capture uses both edges
// - Common clock never latches data words
// - Flow control spans four clocks every rate
// - 8-byte quad read gets 8 padding bytes
// - Strobes keep toggling through padding phases
// - Critical quadword always goes first
// - Byte enables off for padding phases
// - Long quad writes take half the clocks
// - Grant pipelining identical at every rate
// - Back-to-back 16-byte grants pipelined like 2x
// - Double rate: fall first, rise second
// - Read return status codes 000 and 001
`timescale 1ns/1ps
`include "qrs_params.svh"

// ********************************
// Receive buffer
// ********************************
module qrs_fifo #(
  parameter int W = 36,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire empty = wp == rp;
  wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire push = in_valid_i && !full;
  wire load = !empty && (!out_valid_o || out_ready_i);
  assign in_ready_o = !full;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end

  // Output is registered so a stalled drain never sees data change
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (load) begin
        out_data_o <= mem[rp[AW-1:0]];
        rp <= rp + 1'b1;
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule

// ********************************
// Data phase engine
// ********************************
module qrs_xfer
  import qrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Mode selects
  input wire logic rate_4x_i,
  input wire logic cap_diff_i,
  // Read return source
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [127:0] rd_data_i,
  input wire logic rd_two_qw_i,
  input wire logic rd_odd_i,
  input wire logic rd_hi_i,
  // Write grant requests
  input wire logic wr_req_i,
  input wire logic wr_hi_i,
  output logic wr_gnt_o,
  // Received write words
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output qrs_word_t rx_word_o,
  // Common clock and arbiter pins
  input wire logic bus_clk_i,
  output logic grant_n_o,
  output logic [2:0] grant_status_code_o,
  // Ready handshake pin
  input wire logic either_ready_handshake_n_i,
  output logic either_ready_handshake_n_o,
  output logic ready_oe_n_o,
  // Data, byte enable and strobe pins
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_n_o,
  input wire logic [3:0] be_n_i,
  output logic [3:0] be_n_o,
  input wire logic [1:0] data_strobe_true_i,
  input wire logic [1:0] data_strobe_complement_i,
  output logic [1:0] data_strobe_true_o,
  output logic [1:0] data_strobe_complement_o,
  output logic strobe_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // ********************************
  // Pin synchronisers
  // ********************************
  qrs_pins_t pin_raw;
  qrs_pins_t pin_m;
  qrs_pins_t pin_s;
  qrs_pins_t pin_d;
  assign pin_raw = '{
    bus_clk: bus_clk_i,
    ready_n: either_ready_handshake_n_i,
    strobe_t: data_strobe_true_i,
    strobe_c: data_strobe_complement_i,
    be_n: be_n_i,
    ad: ad_i
  };

  // Reset to idle pin levels so no false strobe edge follows reset
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pin_m <= `QRS_PIN_IDLE;
      pin_s <= `QRS_PIN_IDLE;
      pin_d <= `QRS_PIN_IDLE;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  // ********************************
  // Edge decode
  // ********************************
  wire tick = pin_s.bus_clk && !pin_d.bus_clk;
  wire ready_fall = pin_d.ready_n && !pin_s.ready_n;
  wire fall_t = pin_d.strobe_t[0] && !pin_s.strobe_t[0];
  wire rise_t = !pin_d.strobe_t[0] && pin_s.strobe_t[0];
  wire fall_c = pin_d.strobe_c[0] && !pin_s.strobe_c[0];
  wire rise_c = !pin_d.strobe_c[0] && pin_s.strobe_c[0];
  wire dif_s = pin_s.strobe_t[0] && !pin_s.strobe_c[0];
  wire dif_d = pin_d.strobe_t[0] && !pin_d.strobe_c[0];
  wire dif_edge = dif_s ^ dif_d;
  wire sep_edge = fall_t || fall_c;
  wire dbl_edge = fall_t || rise_t;
  wire cap_edge = !rate_4x_i ? dbl_edge
                : (cap_diff_i ? dif_edge : sep_edge);
  wire [2:0] ph_total = rate_4x_i ? `QRS_WORDS_4X : `QRS_WORDS_2X;

  // ********************************
  // Receive staging
  // ********************************
  // Words wait here until the ready handshake is also seen, so the
  // order of strobe and ready within one clock does not matter
  qrs_word_t stage [4];
  logic [2:0] ph_cnt;
  logic [2:0] push_idx;
  logic rx_armed;
  logic rdy_seen;
  logic committing;
  logic fifo_in_ready;
  logic arm_wr;
  wire cap_take = rx_armed && cap_edge && !committing
                && (ph_cnt < ph_total);
  wire block_done = rx_armed && rdy_seen
                  && (ph_cnt == ph_total);
  wire commit_push = committing && fifo_in_ready;
  wire commit_last = commit_push && (push_idx == ph_total - 3'h1);
  wire qrs_word_t commit_word = stage[push_idx[1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (cap_take) begin
      stage[ph_cnt[1:0]] <= '{data: pin_s.ad, be_n: pin_s.be_n};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ph_cnt <= 3'h0;
      push_idx <= 3'h0;
      rx_armed <= 1'b0;
      rdy_seen <= 1'b0;
      committing <= 1'b0;
    end else begin
      // A new ready beats the clear at block done
      // Our own read ready shows on the pin too, so only armed ones count
      rdy_seen <= (ready_fall && rx_armed) || (rdy_seen && !block_done);
      rx_armed <= arm_wr || (rx_armed && !block_done);
      if (cap_take) begin
        ph_cnt <= ph_cnt + 3'h1;
      end else if (block_done) begin
        ph_cnt <= 3'h0;
      end
      if (block_done) begin
        committing <= 1'b1;
      end else if (commit_last) begin
        committing <= 1'b0;
      end
      if (commit_last) begin
        push_idx <= 3'h0;
      end else if (commit_push) begin
        push_idx <= push_idx + 3'h1;
      end
    end
  end

  // Padding words keep their disabled enables for the consumer
  qrs_fifo #(
    .W(`QRS_FIFO_WIDTH),
    .D(`QRS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_sys_i),
    .rst_n_i(reset_n_i),
    .in_valid_i(committing),
    .in_ready_o(fifo_in_ready),
    .in_data_i(commit_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_word_o)
  );

  // ********************************
  // Grant pipeline
  // ********************************
  qrs_slot_t slot_g;
  qrs_rd_t tx_g;
  // Writes wait while the buffer is full or still committing a block
  wire grab_rd = rd_valid_i;
  wire grab_wr = !rd_valid_i && wr_req_i
               && fifo_in_ready && !committing;
  wire qrs_slot_t next_slot = grab_rd ? SLOT_RD
                            : (grab_wr ? SLOT_WR : SLOT_IDLE);
  wire [2:0] rd_code = rd_hi_i ? `QRS_ST_RD_HI : `QRS_ST_RD_LO;
  wire [2:0] wr_code = wr_hi_i ? `QRS_ST_WR_HI : `QRS_ST_WR_LO;
  wire [2:0] next_code = grab_rd ? rd_code
                       : (grab_wr ? wr_code : `QRS_ST_IDLE);
  wire start_rd = tick && (slot_g == SLOT_RD);
  assign arm_wr = tick && grab_wr;

  // A new grant may go out in the data clock of the previous one
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      slot_g <= SLOT_IDLE;
      tx_g <= '0;
      grant_n_o <= 1'b1;
      grant_status_code_o <= `QRS_ST_IDLE;
      rd_ready_o <= 1'b0;
      wr_gnt_o <= 1'b0;
      either_ready_handshake_n_o <= 1'b1;
      ready_oe_n_o <= 1'b1;
    end else begin
      rd_ready_o <= tick && grab_rd;
      wr_gnt_o <= tick && grab_wr;
      if (tick) begin
        slot_g <= next_slot;
        grant_n_o <= next_slot == SLOT_IDLE;
        grant_status_code_o <= next_code;
        either_ready_handshake_n_o <= !start_rd;
        ready_oe_n_o <= !start_rd && either_ready_handshake_n_o;
      end
      if (tick && grab_rd) begin
        tx_g <= '{data: rd_data_i, two_qw: rd_two_qw_i,
                  odd: rd_odd_i};
      end
    end
  end

  // ********************************
  // Transmit phases
  // ********************************
  logic tx_run;
  logic tx_pad;
  logic [2:0] pcyc;
  logic [2:0] pidx;
  logic [127:0] tx_sh;
  wire [63:0] qw_lo = tx_g.data[63:0];
  wire [63:0] qw_hi = tx_g.data[127:64];
  wire [63:0] qw_a = tx_g.odd ? qw_hi : qw_lo;
  wire [63:0] qw_b = tx_g.odd ? qw_lo : qw_hi;
  wire [2:0] ph_len = rate_4x_i ? `QRS_PH_4X : `QRS_PH_2X;
  // Strobe flips half a phase apart from any word change, never with it
  wire [2:0] ph_half = (ph_len >> 1) - 3'h1;
  wire phase_end = tx_run && (pcyc == ph_len - 3'h1);
  wire last_phase = pidx == ph_total - 3'h1;
  wire [2:0] next_idx = pidx + 3'h1;
  wire next_pad = tx_pad && (next_idx >= `QRS_PAD_FROM);
  wire strobe_flip = tx_run && (pcyc == ph_half);

  // Strobes come from the system clock, a full toggle set per clock
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_run <= 1'b0;
      tx_pad <= 1'b0;
      pcyc <= 3'h0;
      pidx <= 3'h0;
      tx_sh <= '0;
      ad_o <= '0;
      ad_oe_n_o <= 1'b1;
      be_n_o <= `QRS_BE_OFF;
      data_strobe_true_o <= `QRS_STB_T_IDLE;
      data_strobe_complement_o <= `QRS_STB_C_IDLE;
      strobe_oe_n_o <= 1'b1;
    end else if (start_rd) begin
      tx_run <= 1'b1;
      tx_pad <= !tx_g.two_qw;
      pcyc <= 3'h0;
      pidx <= 3'h0;
      tx_sh <= {32'h0, qw_b, qw_a[63:32]};
      ad_o <= qw_a[31:0];
      ad_oe_n_o <= 1'b0;
      be_n_o <= `QRS_BE_ON;
      strobe_oe_n_o <= 1'b0;
    end else if (tx_run) begin
      pcyc <= phase_end ? 3'h0 : pcyc + 3'h1;
      if (strobe_flip) begin
        data_strobe_true_o <= ~data_strobe_true_o;
        data_strobe_complement_o <= ~data_strobe_complement_o;
      end
      if (phase_end && last_phase) begin
        tx_run <= 1'b0;
        ad_oe_n_o <= 1'b1;
        strobe_oe_n_o <= 1'b1;
        be_n_o <= `QRS_BE_OFF;
      end else if (phase_end) begin
        pidx <= next_idx;
        ad_o <= tx_sh[31:0];
        tx_sh <= {32'h0, tx_sh[127:32]};
        be_n_o <= next_pad ? `QRS_BE_OFF : `QRS_BE_ON;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  a_phase_span: assert property (
    $rose(tx_run) |-> ##7 tx_run ##1 !tx_run)
    else $error("phase burst length wrong");
  a_strobe_idle: assert property (
    $fell(tx_run) |-> data_strobe_true_o[0]
      && !data_strobe_complement_o[0])
    else $error("strobes did not complete all toggles");
  a_pad_enables: assert property (
    phase_end && !last_phase && next_pad |=> be_n_o == `QRS_BE_OFF)
    else $error("padding phase has enables on");
  a_read_code: assert property (
    !grant_n_o && slot_g == SLOT_RD
      |-> grant_status_code_o inside {`QRS_ST_RD_LO, `QRS_ST_RD_HI})
    else $error("read grant with wrong status");
  a_ready_follows: assert property (
    start_rd |=> !either_ready_handshake_n_o && !ready_oe_n_o
      && tx_run && ad_o == $past(qw_a[31:0]))
    else $error("ready or data late after read grant");
  a_comp_rise: assert property (
    rate_4x_i && !cap_diff_i && rise_c && !fall_t |-> !cap_edge)
    else $error("capture on complement rise");
  a_commit_ready: assert property (
    $rose(committing) |-> $past(rdy_seen) && $past(ph_cnt) == ph_total)
    else $error("words committed before ready");
  a_write_grant: assert property (
    wr_gnt_o |-> !grant_n_o && grant_status_code_o[1]
      && slot_g == SLOT_WR)
    else $error("write grant pulse without write status");
endmodule

// ==== verilog/qrs_params.svh ====
// Constants for the quad-rate strobe data transfer block
`ifndef QRS_PARAMS_SVH
`define QRS_PARAMS_SVH
// Grant status codes
`define QRS_ST_RD_LO 3'h0
`define QRS_ST_RD_HI 3'h1
`define QRS_ST_WR_LO 3'h2
`define QRS_ST_WR_HI 3'h3
`define QRS_ST_IDLE 3'h7
// Byte enables, active low
`define QRS_BE_ON 4'h0
`define QRS_BE_OFF 4'hf
// System cycles per data phase
`define QRS_PH_2X 3'h4
`define QRS_PH_4X 3'h2
// Data phases per common clock
`define QRS_WORDS_2X 3'h2
`define QRS_WORDS_4X 3'h4
// First padding phase of an 8-byte read
`define QRS_PAD_FROM 3'h2
// Receive buffer
`define QRS_FIFO_WIDTH 36
`define QRS_FIFO_DEPTH 8
// Pin idle levels: ready high, true high, complement low
`define QRS_PIN_IDLE 42'h1cf00000000
`define QRS_STB_T_IDLE 2'h3
`define QRS_STB_C_IDLE 2'h0
`endif

// ==== verilog/qrs_pkg.sv ====
// Types for the quad-rate strobe data transfer block
package qrs_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be_n;
  } qrs_word_t;
  typedef struct packed {
    logic bus_clk;
    logic ready_n;
    logic [1:0] strobe_t;
    logic [1:0] strobe_c;
    logic [3:0] be_n;
    logic [31:0] ad;
  } qrs_pins_t;
  typedef struct packed {
    logic [127:0] data;
    logic two_qw;
    logic odd;
  } qrs_rd_t;
  typedef enum logic [2:0] {
    SLOT_IDLE = 3'b001,
    SLOT_RD = 3'b010,
    SLOT_WR = 3'b100
  } qrs_slot_t;
endpackage

// ==== test/qrs_master.sv ====
// Behavioural graphics master facing the data phase engine
`timescale 1ns/1ps
module qrs_master
  import qrs_pkg::*;
(
  // Pins seen
  input wire logic bus_clk_i,
  input wire logic rate_4x_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] be_n_i,
  input wire logic stb_t_i,
  input wire logic stb_oe_n_i,
  // Pins driven
  output logic drv_o,
  output logic ready_n_o,
  output logic [31:0] ad_o,
  output logic [3:0] be_n_o,
  output logic [1:0] stb_t_o,
  output logic [1:0] stb_c_o
);
  qrs_word_t rq[$];
  int useful = 0;
  initial begin
    drv_o = 1'b0;
    ready_n_o = 1'b1;
    ad_o = 32'h0;
    be_n_o = 4'hf;
    stb_t_o = 2'h3;
    stb_c_o = 2'h0;
  end
  // ****************
  // Read capture
  // ****************
  // Strobe edges only, never the common clock
  always @(stb_t_i) begin
    if (stb_oe_n_i === 1'b0) begin
      rq.push_back({ad_i, be_n_i});
      if (be_n_i !== 4'hf) useful++;
    end
  end
  // ****************
  // Write source
  // ****************
  // Strobe toggles mid-phase so each edge has setup and hold
  task automatic send(input int n, input int pad, input int skew,
      input bit late);
    int half;
    half = rate_4x_i ? 6 : 12;
    @(posedge bus_clk_i);
    #(skew);
    drv_o = 1'b1;
    ready_n_o = late;
    for (int i = 0; i < n; i++) begin
      ad_o = 32'hb0 + 32'(i);
      be_n_o = (i >= pad) ? 4'hf : 4'h0;
      #(half);
      stb_t_o = ~stb_t_o;
      stb_c_o = ~stb_c_o;
      #(half);
    end
    @(posedge bus_clk_i);
    #2;
    ready_n_o = !late;
    if (late) begin
      @(posedge bus_clk_i);
      #2;
      ready_n_o = 1'b1;
    end
    drv_o = 1'b0;
    ad_o = ~ad_o;
    be_n_o = ~be_n_o;
  endtask
endmodule

// ==== test/qrs_xfer_bench.sv ====
// Self-checking bench for the data phase engine
`timescale 1ns/1ps
module qrs_xfer_bench
  import qrs_pkg::*;
;
  logic clk_sys_i, reset_n_i, rate_4x_i, cap_diff_i, bus_clk_i;
  logic rd_valid_i, rd_two_qw_i, rd_odd_i, rd_hi_i;
  logic wr_req_i, wr_hi_i, rx_ready_i;
  logic [127:0] rd_data_i;
  logic rd_ready_o, wr_gnt_o, rx_valid_o, grant_n_o;
  logic either_ready_handshake_n_o, ready_oe_n_o, ad_oe_n_o;
  logic strobe_oe_n_o, m_drv, m_rdy;
  logic [2:0] grant_status_code_o;
  logic [31:0] ad_o, m_ad;
  logic [3:0] be_n_o, m_be;
  logic [1:0] data_strobe_true_o, data_strobe_complement_o, m_t, m_c;
  qrs_word_t rx_word_o;
  qrs_word_t rxq[$];
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  // ****************
  // Pins resolved; strobes pulled to idle
  // ****************
  wire rdy_w = !ready_oe_n_o ? either_ready_handshake_n_o : m_rdy;
  wire [31:0] ad_w = !ad_oe_n_o ? ad_o : m_ad;
  wire [3:0] be_w = !ad_oe_n_o ? be_n_o : m_be;
  wire [1:0] t_w = !strobe_oe_n_o ? data_strobe_true_o
                                  : (m_drv ? m_t : 2'h3);
  wire [1:0] c_w = !strobe_oe_n_o ? data_strobe_complement_o
                                  : (m_drv ? m_c : 2'h0);
  qrs_xfer i_qrs_xfer (.clk_sys_i, .reset_n_i, .rate_4x_i, .cap_diff_i,
    .rd_valid_i, .rd_ready_o, .rd_data_i, .rd_two_qw_i, .rd_odd_i,
    .rd_hi_i, .wr_req_i, .wr_hi_i, .wr_gnt_o, .rx_valid_o, .rx_ready_i,
    .rx_word_o, .bus_clk_i, .grant_n_o, .grant_status_code_o,
    .either_ready_handshake_n_i(rdy_w), .either_ready_handshake_n_o,
    .ready_oe_n_o, .ad_i(ad_w), .ad_o, .ad_oe_n_o, .be_n_i(be_w),
    .be_n_o, .data_strobe_true_i(t_w), .data_strobe_complement_i(c_w),
    .data_strobe_true_o, .data_strobe_complement_o, .strobe_oe_n_o);
  qrs_master i_qrs_master (.bus_clk_i, .rate_4x_i, .ad_i(ad_w),
    .be_n_i(be_w), .stb_t_i(t_w[0]), .stb_oe_n_i(strobe_oe_n_o),
    .drv_o(m_drv), .ready_n_o(m_rdy), .ad_o(m_ad), .be_n_o(m_be),
    .stb_t_o(m_t), .stb_c_o(m_c));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Common clock free running, phase unrelated to the system clock
  initial begin
    bus_clk_i = 1'b0;
    #7;
    forever #32 bus_clk_i = ~bus_clk_i;
  end
  always @(posedge clk_sys_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) rxq.push_back(rx_word_o);
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp,
      input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_read(input bit r4, two, odd, hi, input int reps);
    int n, gap, k, src, u;
    qrs_word_t w;
    n = r4 ? 4 : 2;
    i_qrs_master.rq.delete();
    i_qrs_master.useful = 0;
    @(posedge clk_sys_i);
    rate_4x_i <= r4;
    rd_two_qw_i <= two;
    rd_odd_i <= odd;
    rd_hi_i <= hi;
    rd_data_i <= {32'h44, 32'h33, 32'h22, 32'h11};
    rd_valid_i <= 1'b1;
    for (int j = 0; j < reps; j++) begin
      gap = 0;
      do begin
        @(posedge clk_sys_i);
        gap++;
      end while (rd_ready_o !== 1'b1 && gap < 40);
      cmp(36'(grant_n_o), 36'h0, "read grant");
      cmp(36'(grant_status_code_o), {35'h0, hi}, "read status");
      if (j > 0) cmp(36'(gap <= 14), 36'h1, "read grant gap");
    end
    rd_valid_i <= 1'b0;
    k = 0;
    while ((i_qrs_master.rq.size() < n * reps || strobe_oe_n_o !== 1'b1)
        && k < 80) begin
      @(posedge clk_sys_i);
      k++;
    end
    cmp(36'(i_qrs_master.rq.size()), 36'(n * reps), "read count");
    u = (r4 && !two) ? 2 * reps : n * reps;
    cmp(36'(i_qrs_master.useful), 36'(u), "useful words");
    for (k = 0; k < n * reps; k++) begin
      w = i_qrs_master.rq[k];
      src = odd ? (k % n) ^ 2 : k % n;
      if (r4 && !two && k % n >= 2)
        cmp(36'(w.be_n), 36'hf, "padding enables");
      else
        cmp(w, {32'(17 * (src + 1)), 4'h0}, "read word");
    end
  endtask
  task automatic do_write(input bit r4, diff, input int n, pad, skew,
      input bit late);
    int k;
    @(posedge clk_sys_i);
    rate_4x_i <= r4;
    cap_diff_i <= diff;
    wr_hi_i <= late;
    wr_req_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wr_gnt_o !== 1'b1 && k < 80);
    cmp(36'(grant_status_code_o), {34'h0, 1'b1, late}, "wr status");
    wr_req_i <= 1'b0;
    i_qrs_master.send(n, pad, skew, late);
  endtask
  task automatic rx_expect(input int n, pad);
    int k;
    k = 0;
    while (rxq.size() < n && k < 80) begin
      @(posedge clk_sys_i);
      k++;
    end
    cmp(36'(rxq.size()), 36'(n), "write count");
    for (k = 0; k < n; k++)
      cmp(rxq[k], {32'hb0 + 32'(k % 4), (k % 4 >= pad) ? 4'hf : 4'h0},
          "write word");
    rxq.delete();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_idle();
    cmp(36'({grant_n_o, grant_status_code_o}), 36'hf, "idle grant");
    cmp(36'({ready_oe_n_o, ad_oe_n_o, strobe_oe_n_o}), 36'h7, "idle oe");
    cmp(36'({data_strobe_true_o, data_strobe_complement_o}), 36'hc,
        "idle strobes");
  endtask
  task automatic t_reads();
    do_read(1, 1, 0, 0, 1);
    do_read(1, 1, 1, 1, 1);
    do_read(1, 0, 1, 0, 1);
    do_read(0, 1, 1, 1, 1);
  endtask
  task automatic t_back_to_back();
    do_read(1, 1, 0, 0, 2);
    do_read(0, 1, 0, 1, 2);
  endtask
  task automatic t_writes();
    do_write(1, 0, 4, 4, 2, 0);
    rx_expect(4, 4);
    do_write(1, 0, 4, 4, 14, 1);
    rx_expect(4, 4);
    do_write(1, 1, 4, 4, 8, 0);
    rx_expect(4, 4);
    do_write(1, 0, 4, 2, 2, 1);
    rx_expect(4, 2);
    do_write(0, 0, 2, 4, 2, 0);
    rx_expect(2, 4);
  endtask
  // Consumer stalls; third block fills the buffer and stalls its commit,
  // so a fourth grant must be refused
  task automatic t_fill();
    bit g;
    g = 1'b0;
    @(posedge clk_sys_i);
    rx_ready_i <= 1'b0;
    repeat (3) do_write(1, 0, 4, 4, 2, 0);
    @(posedge clk_sys_i);
    wr_req_i <= 1'b1;
    repeat (60) begin
      @(posedge clk_sys_i);
      if (wr_gnt_o === 1'b1) g = 1'b1;
    end
    cmp(36'(g), 36'h0, "grant while full");
    cmp(36'(rx_valid_o), 36'h1, "stalled words");
    wr_req_i <= 1'b0;
    rx_ready_i <= 1'b1;
    rx_expect(12, 4);
    repeat (4) @(posedge clk_sys_i);
    cmp(36'(rx_valid_o), 36'h0, "buffer not empty");
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    reset_n_i = 1'b0;
    rate_4x_i = 1'b1;
    cap_diff_i = 1'b0;
    rd_valid_i = 1'b0;
    rd_data_i = 128'h0;
    rd_two_qw_i = 1'b1;
    rd_odd_i = 1'b0;
    rd_hi_i = 1'b0;
    wr_req_i = 1'b0;
    wr_hi_i = 1'b0;
    rx_ready_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_idle();
    t_reads();
    t_back_to_back();
    t_writes();
    t_fill();
    stop_test();
  end
endmodule
